//--- hdl/pcs_sequencer.sv
// Fetch pointer sequencer: next-address logic of the core.
// Assumes cycle_en pulses once per instruction cycle from the core divider.
// Assumes variant is a build-time strap, so it needs no synchroniser.
// Function
// RULE1: Pointer holds next address, adds one each instruction cycle unless loaded.
// RULE2: Direct jump loads pointer bits 8:0 from the instruction target field.
// RULE3: Low pointer byte is a file location read and written directly.
// RULE4: Multi-page variants copy status bits 5,6 into pointer bits 9,10 on loads.
// RULE5: Call or low-byte write takes pointer bits 7:0 from word or result.
// RULE6: Call or low-byte write forces pointer bit eight to zero.
// RULE7: Move, add and bit-set-five into the low byte count as low-byte writes.
// RULE8: Pages are 512 words; call targets fall in first 256 words of page.
// RULE9: Pointer width follows memory size; increments wrap at that width.
`timescale 1ns/1ps
`default_nettype none
module pcs_sequencer (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cycle_en,
    // Variant strap, held static
    input wire logic [1:0] variant,
    // From decoder and data path
    input wire logic [pcs_pkg::PCS_INSN_W-1:0] insn,
    input wire logic [pcs_pkg::PCS_DATA_W-1:0] alu_result,
    input wire logic [pcs_pkg::PCS_DATA_W-1:0] status_reg,
    // To program memory fetch and file read mux
    output logic [pcs_pkg::PCS_PTR_W-1:0] fetch_pointer,
    output logic [pcs_pkg::PCS_DATA_W-1:0] fetch_pointer_low_byte
);
    import pcs_pkg::*;

    // Source of the next pointer value, one-hot
    typedef enum logic [4:0] {
        SRC_HOLD = 5'h01,
        SRC_STEP = 5'h02,
        SRC_JUMP = 5'h04,
        SRC_CALL = 5'h08,
        SRC_LOW = 5'h10
    } pcs_src_type;

    typedef struct packed {
        logic [PCS_PTR_W-1:0] ptr;
    } pcs_state_type;

    // Registered state and its next value
    pcs_state_type st_r;
    pcs_state_type st_nxt;

    // Decoder outputs
    logic is_jump;
    logic is_call;
    logic is_low_write;

    // Operands of each source
    pcs_src_type src;
    logic [PCS_PTR_W-1:0] mask;
    logic [PCS_PTR_W-1:0] reset_val;
    logic [PCS_PTR_W-1:0] page;
    logic [PCS_DATA_W-1:0] call_low;
    logic [PCS_PTR_W-1:0] jump_val;
    logic [PCS_PTR_W-1:0] call_val;
    logic [PCS_PTR_W-1:0] low_val;

    // Increment chain
    wire logic [PCS_PTR_W-1:0] carry;
    wire logic [PCS_PTR_W-1:0] step_val;

    // Select and mask
    logic [PCS_PTR_W-1:0] cand;
    wire logic [PCS_PTR_W-1:0] cand_masked;

    // Instruction classes
    pcs_decode u_dec (
        .insn(insn),
        .is_jump(is_jump),
        .is_call(is_call),
        .is_low_write(is_low_write)
    );

    // Width mask per variant; the spare code falls back to one page [RULE9]
    function automatic logic [PCS_PTR_W-1:0] ptr_mask(input logic [1:0] v);
        case (v)
            PCS_VAR_ONE_PAGE: ptr_mask = 11'h1FF;
            PCS_VAR_TWO_PAGE: ptr_mask = 11'h3FF;
            PCS_VAR_FOUR_PAGE: ptr_mask = 11'h7FF;
            default: ptr_mask = 11'h1FF;
        endcase
    endfunction : ptr_mask

    // Page field from status; small maps lose it to the mask [RULE4] [RULE8]
    function automatic logic [PCS_PTR_W-1:0] page_bits(
        input logic [PCS_DATA_W-1:0] s
    );
        page_bits = PCS_ZERO;
        page_bits[PCS_PAGE_LO +: 2] = s[PCS_STATUS_PAGE_LO +: 2];
    endfunction : page_bits

    // Nine-bit target within the selected page [RULE2]
    function automatic logic [PCS_PTR_W-1:0] jump_target(
        input logic [PCS_PTR_W-1:0] pg,
        input logic [PCS_INSN_W-1:0] w
    );
        jump_target = pg;
        jump_target[PCS_JUMP_HI:0] = w[PCS_JUMP_HI:0];
    endfunction : jump_target

    // Shared by call and low-byte write: bit eight cleared, so only the
    // first half of a page is reachable this way [RULE5] [RULE6] [RULE8]
    function automatic logic [PCS_PTR_W-1:0] low_target(
        input logic [PCS_PTR_W-1:0] pg,
        input logic [PCS_DATA_W-1:0] lo
    );
        low_target = pg;
        low_target[PCS_LOW_HI:0] = lo;
        low_target[PCS_BIT8] = 1'b0;
    endfunction : low_target

    // Priority is moot: the decoder classes are disjoint [RULE1]
    function automatic pcs_src_type pick_src(
        input logic en,
        input logic jmp,
        input logic cal,
        input logic low
    );
        if (!en) begin
            pick_src = SRC_HOLD;
        end else if (jmp) begin
            pick_src = SRC_JUMP;
        end else if (cal) begin
            pick_src = SRC_CALL;
        end else if (low) begin
            pick_src = SRC_LOW;
        end else begin
            pick_src = SRC_STEP;
        end
    endfunction : pick_src

    // Ripple increment; the carry out of the top bit is dropped [RULE1] [RULE9]
    assign carry[0] = 1'b1;
    genvar gi;
    generate
        for (gi = 0; gi < PCS_PTR_W; gi = gi + 1) begin : g_step
            assign step_val[gi] = st_r.ptr[gi] ^ carry[gi];
            if (gi < PCS_PTR_W - 1) begin : g_carry
                assign carry[gi + 1] = st_r.ptr[gi] & carry[gi];
            end
        end
    endgenerate

    // Bits above the variant's width stay clear, so wrap is modulo width [RULE9]
    generate
        for (gi = 0; gi < PCS_PTR_W; gi = gi + 1) begin : g_mask
            assign cand_masked[gi] = cand[gi] & mask[gi];
        end
    endgenerate

    // Width of this variant and the masked reset value [RULE9]
    always_comb begin
        mask = ptr_mask(variant);
        reset_val = PCS_PTR_RESET & mask;
    end

    // Page field for all three load kinds [RULE4]
    always_comb begin
        page = page_bits(status_reg);
    end

    // Direct jump operand [RULE2]
    always_comb begin
        jump_val = jump_target(page, insn);
    end

    // Call operand from the literal field [RULE5] [RULE6]
    always_comb begin
        call_low = insn[PCS_LOW_HI:0];
        call_val = low_target(page, call_low);
    end

    // Low-byte write operand from the computed result [RULE3] [RULE7]
    always_comb begin
        low_val = low_target(page, alu_result);
    end

    // Source for this cycle [RULE1]
    always_comb begin
        src = pick_src(cycle_en, is_jump, is_call, is_low_write);
    end

    // Hold keeps the pointer when the cycle is not enabled [RULE1]
    always_comb begin
        case (src)
            SRC_STEP: cand = step_val;
            SRC_JUMP: cand = jump_val;
            SRC_CALL: cand = call_val;
            SRC_LOW: cand = low_val;
            SRC_HOLD: cand = st_r.ptr;
            default: cand = st_r.ptr;
        endcase
    end

    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.ptr = cand_masked; // [RULE4] [RULE9]
    end

    // Reset vector lives outside; all-ones reaches the top of any map
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            st_r <= '{ptr: reset_val};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from the register, already masked
    assign fetch_pointer = st_r.ptr;
    assign fetch_pointer_low_byte = st_r.ptr[PCS_LOW_HI:0]; // [RULE3]
endmodule : pcs_sequencer
`default_nettype wire

//--- hdl/pcs_pkg.sv
// Package for the fetch pointer sequencer: widths, field positions, codes.
// Assumes a 12-bit instruction word and an 8-bit register file data path.
package pcs_pkg;
    localparam int PCS_PTR_W = 11;
    localparam int PCS_INSN_W = 12;
    localparam int PCS_DATA_W = 8;
    localparam int PCS_FILE_ADDR_W = 5;
    // Low-byte pointer location in the register file
    localparam logic [4:0] PCS_LOW_BYTE_ADDR = 5'h02;
    // Pages of the variants: 1, 2 or 4 pages of 512 words
    localparam logic [1:0] PCS_VAR_ONE_PAGE = 2'h0;
    localparam logic [1:0] PCS_VAR_TWO_PAGE = 2'h1;
    localparam logic [1:0] PCS_VAR_FOUR_PAGE = 2'h2;
    // Field positions
    localparam int PCS_JUMP_HI = 8;
    localparam int PCS_LOW_HI = 7;
    localparam int PCS_BIT8 = 8;
    localparam int PCS_PAGE_LO = 9;
    localparam int PCS_STATUS_PAGE_LO = 5;
    // Opcode patterns of the upper bits
    localparam logic [2:0] PCS_OP_JUMP = 3'h5;       // 101k kkkk kkkk
    localparam logic [3:0] PCS_OP_CALL = 4'h9;       // 1001 kkkk kkkk
    localparam logic [6:0] PCS_OP_MOVE = 7'h01;      // 0000 001f ffff
    localparam logic [5:0] PCS_OP_ADD = 6'h07;       // 0001 11df ffff
    localparam logic [3:0] PCS_OP_BSET = 4'h5;       // 0101 bbbf ffff
    localparam logic [2:0] PCS_BSET_BIT = 3'h5;
    localparam logic [10:0] PCS_PTR_RESET = 11'h7FF;
    localparam logic [10:0] PCS_ZERO = 11'h000;
endpackage : pcs_pkg

//--- hdl/pcs_decode.sv
// Classifies an instruction word for the sequencer.
// Assumes the word is stable for the whole instruction cycle.
`timescale 1ns/1ps
`default_nettype none
module pcs_decode (
    // Instruction
    input wire logic [pcs_pkg::PCS_INSN_W-1:0] insn,
    // Class
    output logic is_jump,
    output logic is_call,
    output logic is_low_write
);
    import pcs_pkg::*;
    logic to_low;
    assign to_low = (insn[4:0] == PCS_LOW_BYTE_ADDR);
    assign is_jump = (insn[11:9] == PCS_OP_JUMP); // [RULE2]
    assign is_call = (insn[11:8] == PCS_OP_CALL); // [RULE5]
    // Add targets the file only when d is set [RULE7]
    assign is_low_write = to_low & ((insn[11:5] == PCS_OP_MOVE)
        | (insn[11:6] == PCS_OP_ADD && insn[5])
        | (insn[11:8] == PCS_OP_BSET && insn[7:5] == PCS_BSET_BIT));
endmodule : pcs_decode
`default_nettype wire

//--- testbench/pcs_insn_model.sv
// Word source on the decoder side; rnd picks the class.
// Assumes rnd is driven off the clock edge by the bench.
`timescale 1ns/1ps
`default_nettype none
module pcs_insn_model (
    // Selector and operand bits
    input wire logic [11:0] rnd,
    // Word to the sequencer
    output logic [11:0] insn
);
    always_comb begin
        case (rnd[11:9])
            3'h0: insn = {3'h5, rnd[8:0]};
            3'h1: insn = {4'h9, rnd[7:0]};
            3'h2: insn = 12'h022;
            3'h3: insn = 12'h1E2;
            3'h4: insn = 12'h5A2;
            3'h5: insn = 12'h1C2;
            3'h6: insn = {4'hC, rnd[7:0]};
            default: insn = {7'h01, rnd[4:0]};
        endcase
    end
endmodule : pcs_insn_model
`default_nettype wire

//--- testbench/pcs_seq_props.sv
// Port checks; variant held static out of reset.
`timescale 1ns/1ps
`default_nettype none
module pcs_seq_props (
    // Clock, reset, strap
    input wire logic mclk,
    input wire logic nrst,
    input wire logic cycle_en,
    input wire logic [1:0] variant,
    // Sequencer inputs
    input wire logic [11:0] insn,
    input wire logic [7:0] alu_result,
    input wire logic [7:0] status_reg,
    // Sequencer outputs
    input wire logic [10:0] fetch_pointer,
    input wire logic [7:0] fetch_pointer_low_byte
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire logic [10:0] p = fetch_pointer, m = {variant[1], |variant, 9'h1FF};
    wire logic j = cycle_en && insn[11:9] == 3'h5, c = cycle_en && insn[11:8] == 4'h9;
    wire logic l = cycle_en && insn[4:0] == 5'h02 && insn[11:5] inside {7'h01, 7'h0F, 7'h2D};
    a_hold_idle: assert property (!cycle_en |=> $stable(p)) else $error("hold");
    a_step_one: assert property (cycle_en && insn[11:10] == 2'h3 |=>
        p == ($past(p) + 11'h1 & m)) else $error("step");
    a_jump_low: assert property (j |=> p[8:0] == $past(insn[8:0])) else $error("jump");
    a_low_mirror: assert property (fetch_pointer_low_byte == p[7:0]) else $error("low");
    a_page_copy: assert property (j || c || l |=>
        p[10:9] == ($past(status_reg[6:5]) & m[10:9])) else $error("page");
    a_call_low: assert property (c |=> p[8:0] == $past(insn[7:0])) else $error("call");
    a_write_low: assert property (l |=> p[8:0] == $past(alu_result)) else $error("wr");
    a_width_mask: assert property ((p & ~m) == 11'h0) else $error("mask");
    a_add_kept: assert property (cycle_en && insn == 12'h1C2 |=>
        p == ($past(p) + 11'h1 & m)) else $error("add d0");
endmodule : pcs_seq_props
bind pcs_sequencer pcs_seq_props u_props (.*);
`default_nettype wire

//--- testbench/pcs_sequencer_tb.sv
// Random words per variant; queue scoreboard.
// Assumes the variant strap only changes while reset is held.
`timescale 1ns/1ps
`default_nettype none
module pcs_sequencer_tb;
    logic mclk = 0, nrst = 0, cycle_en = 0;
    logic [1:0] variant = 0;
    logic [2:0] h;
    logic [7:0] alu_result = 0, status_reg = 0;
    logic [11:0] rnd = 0;
    logic [10:0] q[$], e, m, x, n;
    wire logic [11:0] insn;
    wire logic [10:0] fetch_pointer;
    wire logic [7:0] fetch_pointer_low_byte;
    int n_errors = 0, n_compared = 0, seed = 75489;
    always #2 mclk = ~mclk;
    pcs_insn_model i_src (
        .rnd(rnd),
        .insn(insn)
    );
    pcs_sequencer i_dut (
        .mclk(mclk),
        .nrst(nrst),
        .cycle_en(cycle_en),
        .variant(variant),
        .insn(insn),
        .alu_result(alu_result),
        .status_reg(status_reg),
        .fetch_pointer(fetch_pointer),
        .fetch_pointer_low_byte(fetch_pointer_low_byte)
    );
    task automatic summarize;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    always @(posedge mclk) if (q.size() > 0) begin
        #1 x = q.pop_front();
        n_compared++;
        if ({fetch_pointer_low_byte, fetch_pointer} !== {x[7:0], x}) begin
            n_errors++;
            $display("BAD fetch_pointer exp %h/%h got %h/%h", x, x[7:0], fetch_pointer,
                fetch_pointer_low_byte);
        end
    end
    initial begin
        for (int v = 0; v < 3; v++) begin
            @(negedge mclk) {nrst, cycle_en, variant} = 4'(v);
            m = {variant[1], |variant, 9'h1FF};
            repeat (4) @(negedge mclk);
            e = pcs_pkg::PCS_PTR_RESET & m;
            q.push_back(e);
            nrst = 1;
            repeat (400) begin
                @(negedge mclk) {cycle_en, status_reg, alu_result, rnd} = 29'($random(seed));
                #1 h = {status_reg[6:5], 1'b0};
                if (insn[11:9] == 3'h5) n = {h[2:1], insn[8:0]};
                else if (insn[11:8] == 4'h9) n = {h, insn[7:0]};
                else if (insn[4:0] == 5'h02 && insn[11:5] inside {7'h01, 7'h0F, 7'h2D})
                    n = {h, alu_result};
                else n = e + 11'h1;
                if (cycle_en) e = n & m;
                q.push_back(e);
            end
            $display("variant %0d done", v);
        end
        @(negedge mclk) summarize();
    end
    initial #20000 begin
        n_errors++;
        summarize();
    end
endmodule : pcs_sequencer_tb
`default_nettype wire
